// >>> core/fpe_host.sv
// Host-side sequencer driving a parallel NOR flash through its pins
`timescale 1ns/1ps
module fpe_host #(
  parameter int WPP1_CYC = fpe_pkg::WPP1_CYC,
  parameter int WPP2_CYC = fpe_pkg::WPP2_CYC,
  parameter int PROG_TO_CYC = fpe_pkg::PROG_TO_CYC,
  parameter int ERASE_TO_CYC = fpe_pkg::ERASE_TO_CYC
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic cmd_valid_in,
  input wire fpe_pkg::fpe_cmd_t cmd_in,
  input wire logic abort_in,
  input wire logic [7:0] flash_dq_in,
  input wire logic flash_ready_busy_n_in,
  output logic busy_out,
  output logic done_out,
  output logic error_out,
  output logic [7:0] rdata_out,
  output logic tu_active_out,
  output fpe_pkg::fpe_pins_t flash_pins_out
);
  // ----------------------------------------
  // State and registers
  // ----------------------------------------
  fpe_pkg::fpe_state_t state_reg, state_next;
  fpe_pkg::fpe_cmd_t cmd_reg;
  fpe_pkg::fpe_pins_t pins_reg, pins_next;
  logic [2:0] step_reg, step_next;
  logic busy_reg, done_reg, error_reg, tu_active_reg, use_ce_reg;
  logic [7:0] rdata_reg, sample_reg, prev_reg;
  logic [1:0] poll_cnt_reg;
  logic ph_load, ph_exp, to_load, to_exp, finish, fail;
  logic [31:0] ph_val, to_val;
  logic [8:0] in_sync;
  wire [7:0] dq_s = in_sync[7:0];
  wire rb_s = in_sync[8];
  wire accept = cmd_valid_in && !busy_reg;
  wire abort_go = abort_in && state_reg != fpe_pkg::S_RST_PULSE && state_reg != fpe_pkg::S_RST_WAIT;

  fpe_sync #(.W(9)) u_sync (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .async_in({flash_ready_busy_n_in, flash_dq_in}),
    .sync_out(in_sync)
  );
  fpe_timer #(.W(32)) u_phase (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .load_in(ph_load),
    .value_in(ph_val),
    .expired_out(ph_exp)
  );
  fpe_timer #(.W(32)) u_timeout (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .load_in(to_load),
    .value_in(to_val),
    .expired_out(to_exp)
  );

  // ----------------------------------------
  // Command sequence table
  // ----------------------------------------
  function automatic fpe_pkg::fpe_step_t seq_entry(input fpe_pkg::fpe_op_t op, input logic [2:0] st,
                                                   input logic [19:0] a, input logic [7:0] d);
    fpe_pkg::fpe_step_t s;
    logic [2:0] u;
    u = (op == fpe_pkg::OP_ERASE && st >= 3'h3) ? 3'(st - 3'h3) : st;
    s.addr = (u == 3'h1) ? fpe_pkg::UNLOCK2_ADDR : fpe_pkg::UNLOCK1_ADDR;
    s.data = (u == 3'h1) ? fpe_pkg::UNLOCK2_DATA : fpe_pkg::UNLOCK1_DATA;
    s.last = 1'b0;
    case (op)
      fpe_pkg::OP_PROGRAM: begin
        if (st == 3'h2) s.data = fpe_pkg::CMD_PROG;
        if (st == 3'h3) s = '{addr: a, data: d, last: 1'b1};
      end
      fpe_pkg::OP_PROGRAM_BYP: begin
        s.data = fpe_pkg::CMD_PROG;
        if (st == 3'h1) s = '{addr: a, data: d, last: 1'b1};
      end
      fpe_pkg::OP_BYP_ENTER: begin
        if (st == 3'h2) s = '{addr: fpe_pkg::UNLOCK1_ADDR, data: fpe_pkg::CMD_BYP_ENTER, last: 1'b1};
      end
      fpe_pkg::OP_BYP_EXIT: begin
        s.data = (st == 3'h0) ? fpe_pkg::CMD_BYP_EXIT1 : fpe_pkg::CMD_BYP_EXIT2;
        s.last = (st == 3'h1);
      end
      fpe_pkg::OP_ERASE: begin
        if (st == 3'h2) s.data = fpe_pkg::CMD_ERASE_SETUP;
        if (st == 3'h5) s = '{addr: a, data: fpe_pkg::CMD_SECTOR_ERASE, last: 1'b1};
      end
      default: s.last = 1'b1;
    endcase
    return s;
  endfunction

  fpe_pkg::fpe_step_t seq;
  assign seq = seq_entry(cmd_reg.op, step_reg, cmd_reg.addr, cmd_reg.data);
  wire is_unprot = (cmd_reg.op == fpe_pkg::OP_UNPROTECT);
  wire embedded = (cmd_reg.op == fpe_pkg::OP_PROGRAM || cmd_reg.op == fpe_pkg::OP_PROGRAM_BYP ||
                   cmd_reg.op == fpe_pkg::OP_ERASE);
  // expected true value of the poll bit
  wire expect7 = (cmd_reg.op == fpe_pkg::OP_ERASE) ? fpe_pkg::ERASED_BIT7 : cmd_reg.data[fpe_pkg::POLL_BIT];
  wire stable = (poll_cnt_reg == 2'h2) && (sample_reg[fpe_pkg::TOGGLE_BIT] == prev_reg[fpe_pkg::TOGGLE_BIT]);
  // erase bounded by its longest time
  wire [31:0] to_sel = (cmd_reg.op == fpe_pkg::OP_ERASE) ? 32'(ERASE_TO_CYC) : 32'(PROG_TO_CYC);
  wire [31:0] wpp_sel = is_unprot ? 32'(WPP2_CYC) : 32'(WPP1_CYC);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    step_next = step_reg;
    ph_load = 1'b0;
    ph_val = 32'(fpe_pkg::PHASE_CYC);
    to_load = 1'b0;
    to_val = to_sel;
    finish = 1'b0;
    fail = 1'b0;
    case (state_reg)
      fpe_pkg::S_IDLE: begin
        if (accept) begin
          ph_load = 1'b1;
          step_next = 3'h0;
          case (cmd_in.op)
            // all-sector checks are plain reads, left to software
            fpe_pkg::OP_READ: state_next = fpe_pkg::S_READ_LO;
            fpe_pkg::OP_PROTECT, fpe_pkg::OP_UNPROTECT: begin
              // strobes set up before the write pulse
              state_next = fpe_pkg::S_HV_SETUP;
              ph_val = 32'(fpe_pkg::SETUP_CYC);
            end
            fpe_pkg::OP_TU_ENTER: begin
              state_next = fpe_pkg::S_TU_RISE;
              ph_val = 32'(fpe_pkg::SETUP_CYC);
            end
            fpe_pkg::OP_TU_EXIT: state_next = fpe_pkg::S_TU_WAIT_RB;
            default: state_next = fpe_pkg::S_WR_LO;
          endcase
        end
      end
      fpe_pkg::S_WR_LO: begin
        if (ph_exp) begin
          state_next = fpe_pkg::S_WR_HI;
          ph_load = 1'b1;
        end
      end
      fpe_pkg::S_WR_HI: begin
        if (ph_exp && !seq.last) begin
          step_next = 3'(step_reg + 3'h1);
          state_next = fpe_pkg::S_WR_LO;
          ph_load = 1'b1;
        end else if (ph_exp && embedded) begin
          state_next = fpe_pkg::S_BUSY_WAIT;
          ph_load = 1'b1;
          ph_val = 32'(fpe_pkg::BUSY_CYC);
          to_load = 1'b1;
        end else if (ph_exp) begin
          finish = 1'b1;
        end
      end
      fpe_pkg::S_BUSY_WAIT, fpe_pkg::S_POLL_HI: begin
        if (ph_exp && state_reg == fpe_pkg::S_POLL_HI && stable) begin
          finish = 1'b1;
          fail = (sample_reg[fpe_pkg::POLL_BIT] != expect7);
        end else if (ph_exp && state_reg == fpe_pkg::S_POLL_HI && to_exp) begin
          finish = 1'b1;
          fail = 1'b1;
        end else if (ph_exp) begin
          state_next = fpe_pkg::S_POLL_LO;
          ph_load = 1'b1;
        end
      end
      fpe_pkg::S_POLL_LO: begin
        if (ph_exp) begin
          state_next = fpe_pkg::S_POLL_HI;
          ph_load = 1'b1;
        end
      end
      fpe_pkg::S_HV_SETUP: begin
        if (ph_exp) begin
          state_next = fpe_pkg::S_HV_PULSE;
          ph_load = 1'b1;
          ph_val = wpp_sel;
        end
      end
      fpe_pkg::S_HV_PULSE: begin
        if (ph_exp) begin
          state_next = fpe_pkg::S_HV_RECOVER;
          ph_load = 1'b1;
        end
      end
      fpe_pkg::S_TU_WAIT_RB: begin
        if (rb_s) begin
          state_next = fpe_pkg::S_TU_HOLD;
          ph_load = 1'b1;
          ph_val = 32'(fpe_pkg::SETUP_CYC);
        end
      end
      fpe_pkg::S_RST_PULSE: begin
        if (ph_exp) begin
          state_next = fpe_pkg::S_RST_WAIT;
          ph_load = 1'b1;
          ph_val = 32'(fpe_pkg::READY_CYC);
        end
      end
      fpe_pkg::S_RST_WAIT: begin
        finish = ph_exp;
        fail = 1'b1;
      end
      default: finish = ph_exp;
    endcase
    if (finish) state_next = fpe_pkg::S_IDLE;
    if (abort_go) begin
      state_next = fpe_pkg::S_RST_PULSE;
      ph_load = 1'b1;
      ph_val = 32'(fpe_pkg::RP_CYC);
      finish = 1'b0;
    end
  end

  // ----------------------------------------
  // Pin decode
  // ----------------------------------------
  wire st_wr = (state_reg == fpe_pkg::S_WR_LO || state_reg == fpe_pkg::S_WR_HI);
  wire st_hv = (state_reg == fpe_pkg::S_HV_SETUP || state_reg == fpe_pkg::S_HV_PULSE ||
                state_reg == fpe_pkg::S_HV_RECOVER);
  wire st_poll_hi = (state_reg == fpe_pkg::S_POLL_HI);
  wire st_rd = (state_reg == fpe_pkg::S_READ_LO || state_reg == fpe_pkg::S_POLL_LO);
  wire st_tu = (state_reg == fpe_pkg::S_TU_RISE || state_reg == fpe_pkg::S_TU_WAIT_RB ||
                state_reg == fpe_pkg::S_TU_HOLD);
  // protect code on the low address bits
  wire [19:0] hv_addr = {cmd_reg.addr[19:7], is_unprot, cmd_reg.addr[5:2], fpe_pkg::PROT_CODE_LO};
  always_comb begin
    pins_next = pins_reg;
    pins_next.ce_n = !(state_reg == fpe_pkg::S_WR_LO || st_rd || st_hv || (st_poll_hi && !use_ce_reg));
    pins_next.oe_n = !(st_rd || state_reg == fpe_pkg::S_HV_SETUP || state_reg == fpe_pkg::S_HV_PULSE ||
                       (st_poll_hi && use_ce_reg));
    pins_next.we_n = !(state_reg == fpe_pkg::S_WR_LO || state_reg == fpe_pkg::S_HV_PULSE);
    // status reads keep the target address, which any address allows
    pins_next.addr = st_wr ? seq.addr : (st_hv ? hv_addr : cmd_reg.addr);
    pins_next.dq = seq.data;
    pins_next.dq_oe = st_wr;
    pins_next.reset_n = (state_reg != fpe_pkg::S_RST_PULSE);
    pins_next.reset_hv = (tu_active_reg || st_tu) && state_reg != fpe_pkg::S_RST_PULSE;
    pins_next.addr_hv = st_hv;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      state_reg <= fpe_pkg::S_IDLE;
      step_reg <= 3'h0;
      cmd_reg <= '0;
      pins_reg <= fpe_pkg::PINS_RESET;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      error_reg <= 1'b0;
      tu_active_reg <= 1'b0;
      use_ce_reg <= 1'b0;
      rdata_reg <= 8'h00;
      sample_reg <= 8'h00;
      prev_reg <= 8'h00;
      poll_cnt_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      step_reg <= step_next;
      pins_reg <= pins_next;
      done_reg <= finish;
      if (finish) error_reg <= fail;
      if (accept && state_reg == fpe_pkg::S_IDLE) cmd_reg <= cmd_in;
      busy_reg <= (state_next != fpe_pkg::S_IDLE);
      if (state_reg == fpe_pkg::S_BUSY_WAIT) poll_cnt_reg <= 2'h0;
      // sample each status read for the toggle compare
      if (state_reg == fpe_pkg::S_POLL_LO && ph_exp) begin
        prev_reg <= sample_reg;
        sample_reg <= dq_s;
        if (poll_cnt_reg != 2'h2) poll_cnt_reg <= 2'(poll_cnt_reg + 2'h1);
      end
      if (st_rd && ph_exp) rdata_reg <= dq_s;
      if (st_poll_hi && ph_exp) use_ce_reg <= !use_ce_reg;
      if (finish && state_reg == fpe_pkg::S_TU_RISE) tu_active_reg <= 1'b1;
      if ((finish && state_reg == fpe_pkg::S_TU_HOLD) || abort_go) tu_active_reg <= 1'b0;
    end
  end
  assign busy_out = busy_reg;
  assign done_out = done_reg;
  assign error_out = error_reg;
  assign rdata_out = rdata_reg;
  assign tu_active_out = tu_active_reg;
  assign flash_pins_out = pins_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Counters: 0 oe low, 1 ce low, 2 we low, 3 reset elevated, 4 rb high while elevated
  logic [4:0] hc_cond;
  logic [31:0] hc_reg [5];
  logic [2:0] wr_cnt_reg;
  assign hc_cond = {rb_s && pins_reg.reset_hv, pins_reg.reset_hv, !pins_reg.we_n, !pins_reg.ce_n, !pins_reg.oe_n};
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_hc
      always_ff @(posedge clock_in) begin
        if (!rst_b_in || !hc_cond[g]) hc_reg[g] <= 32'h0;
        else if (hc_reg[g] != 32'hFFFFFFFF) hc_reg[g] <= hc_reg[g] + 32'h1;
      end
    end
  endgenerate
  always_ff @(posedge clock_in) begin
    if (!rst_b_in || (accept && state_reg == fpe_pkg::S_IDLE)) wr_cnt_reg <= 3'h0;
    else if (pins_next.we_n == 1'b0 && pins_reg.we_n && state_reg == fpe_pkg::S_WR_LO)
      wr_cnt_reg <= 3'(wr_cnt_reg + 3'h1);
  end
  logic we_prev_reg;
  always_ff @(posedge clock_in) we_prev_reg <= !rst_b_in || pins_reg.we_n;
  wire we_fall = !pins_reg.we_n && we_prev_reg;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  property p_protect_code;
    pins_reg.addr_hv && !pins_reg.we_n |-> pins_reg.addr[1:0] == 2'h2 && pins_reg.addr[6] == is_unprot;
  endproperty
  a_protect_code: assert property (p_protect_code) else $error("bad protect address code");
  property p_pulse_width;
    pins_reg.addr_hv && $rose(pins_reg.we_n) |-> hc_reg[2] >= (pins_reg.addr[6] ? WPP2_CYC : WPP1_CYC);
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("protect pulse too short");
  property p_oe_setup;
    pins_reg.addr_hv && we_fall |-> $past(hc_reg[0]) >= fpe_pkg::SETUP_CYC;
  endproperty
  a_oe_setup: assert property (p_oe_setup) else $error("oe setup too short");
  property p_ce_setup;
    pins_reg.addr_hv && we_fall |-> $past(hc_reg[1]) >= fpe_pkg::SETUP_CYC;
  endproperty
  a_ce_setup: assert property (p_ce_setup) else $error("ce setup too short");
  property p_tu_setup;
    pins_reg.reset_hv && !pins_reg.addr_hv && we_fall |-> $past(hc_reg[3]) >= fpe_pkg::SETUP_CYC;
  endproperty
  a_tu_setup: assert property (p_tu_setup) else $error("elevated reset setup too short");
  property p_tu_hold;
    $fell(pins_reg.reset_hv) && pins_reg.reset_n |-> $past(hc_reg[4]) >= fpe_pkg::SETUP_CYC;
  endproperty
  a_tu_hold: assert property (p_tu_hold) else $error("elevated reset hold too short");
  property p_prog_cycles;
    done_reg && !error_reg && cmd_reg.op == fpe_pkg::OP_PROGRAM |-> wr_cnt_reg == 3'h4;
  endproperty
  a_prog_cycles: assert property (p_prog_cycles) else $error("program not four writes");
  property p_byp_cycles;
    done_reg && cmd_reg.op == fpe_pkg::OP_PROGRAM_BYP && pins_reg.reset_n |-> wr_cnt_reg == 3'h2;
  endproperty
  a_byp_cycles: assert property (p_byp_cycles) else $error("bypass program not two writes");
  property p_strobe_between;
    state_reg == fpe_pkg::S_POLL_HI && $past(state_reg) == fpe_pkg::S_POLL_LO |=> pins_reg.oe_n || pins_reg.ce_n;
  endproperty
  a_strobe_between: assert property (p_strobe_between) else $error("no strobe between reads");
  property p_busy_wait;
    $rose(state_reg == fpe_pkg::S_BUSY_WAIT) |=> pins_reg.oe_n [*8];
  endproperty
  a_busy_wait: assert property (p_busy_wait) else $error("polled before busy delay");
  c_prog: cover property (done_reg && !error_reg && cmd_reg.op == fpe_pkg::OP_PROGRAM);
  c_erase: cover property (done_reg && !error_reg && cmd_reg.op == fpe_pkg::OP_ERASE);
  c_unprot: cover property (done_reg && cmd_reg.op == fpe_pkg::OP_UNPROTECT);
  c_tu_exit: cover property ($fell(tu_active_reg) && pins_reg.reset_n);
endmodule

// >>> pkg/fpe_pkg.sv
// Shared constants, types and encodings for the flash sequencer host
package fpe_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_NS = 10;
  localparam int PHASE_NS = 80;
  localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_US = 4;
  localparam int SETUP_CYC = (SETUP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_NS = 90;
  localparam int BUSY_CYC = (BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_NS = 500;
  localparam int RP_CYC = (RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int READY_US = 20;
  localparam int READY_CYC = (READY_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int WPP1_US = 150;
  localparam int WPP1_CYC = (WPP1_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int WPP2_MS = 15;
  localparam int WPP2_CYC = (WPP2_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int PROG_MAX_US = 150;
  localparam int PROG_TO_CYC = PROG_MAX_US * 1000 / CLK_NS;
  localparam int ERASE_MAX_S = 10;
  localparam int ERASE_TO_CYC = int'(64'(ERASE_MAX_S) * 64'd1000000000 / 64'(CLK_NS));
  // ----------------------------------------
  // Bus widths and command words
  // ----------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam logic [19:0] UNLOCK1_ADDR = 20'h00AAA;
  localparam logic [19:0] UNLOCK2_ADDR = 20'h00555;
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] CMD_PROG = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_BYP_ENTER = 8'h20;
  localparam logic [7:0] CMD_BYP_EXIT1 = 8'h90;
  localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;
  localparam logic ERASED_BIT7 = 1'b1;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int PROT_SEL_POS = 6;
  localparam logic [1:0] PROT_CODE_LO = 2'h2;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_PROGRAM = 4'h1,
    OP_PROGRAM_BYP = 4'h2,
    OP_BYP_ENTER = 4'h3,
    OP_BYP_EXIT = 4'h4,
    OP_ERASE = 4'h5,
    OP_PROTECT = 4'h6,
    OP_UNPROTECT = 4'h7,
    OP_TU_ENTER = 4'h8,
    OP_TU_EXIT = 4'h9
  } fpe_op_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_WR_LO = 4'h1,
    S_WR_HI = 4'h2,
    S_BUSY_WAIT = 4'h3,
    S_POLL_LO = 4'h4,
    S_POLL_HI = 4'h5,
    S_READ_LO = 4'h6,
    S_HV_SETUP = 4'h7,
    S_HV_PULSE = 4'h8,
    S_HV_RECOVER = 4'h9,
    S_TU_RISE = 4'hA,
    S_TU_WAIT_RB = 4'hB,
    S_TU_HOLD = 4'hC,
    S_RST_PULSE = 4'hD,
    S_RST_WAIT = 4'hE
  } fpe_state_t;
  typedef struct packed {
    fpe_op_t op;
    logic [19:0] addr;
    logic [7:0] data;
  } fpe_cmd_t;
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [19:0] addr;
    logic [7:0] dq;
    logic dq_oe;
    logic reset_n;
    logic reset_hv;
    logic addr_hv;
  } fpe_pins_t;
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] data;
    logic last;
  } fpe_step_t;
  localparam fpe_pins_t PINS_RESET = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 20'h00000,
    dq: 8'h00, dq_oe: 1'b0, reset_n: 1'b0, reset_hv: 1'b0, addr_hv: 1'b0};
endpackage

// >>> core/fpe_sync.sv
// Two-stage synchroniser for flash pin inputs
`timescale 1ns/1ps
module fpe_sync #(
  parameter int W = 9
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // ----------------------------------------
  // One flop pair per bit
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= async_in[i];
          sync_reg <= meta_reg;
        end
      end
      assign sync_out[i] = sync_reg;
    end
  endgenerate
endmodule

// >>> core/fpe_timer.sv
// Loadable down counter used for phase and timeout intervals
`timescale 1ns/1ps
module fpe_timer #(
  parameter int W = 32
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic load_in,
  input wire logic [W-1:0] value_in,
  output logic expired_out
);
  logic [W-1:0] count_reg;
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      count_reg <= '0;
    end else if (load_in) begin
      count_reg <= value_in;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end
  assign expired_out = (count_reg == '0);
endmodule

// >>> testbench/fpe_flash_model.sv
// Behavioural flash device seen from the host pins
`timescale 1ns/1ps
module fpe_flash_model #(
  parameter int PROG_CYC = 30,
  parameter int ERASE_CYC = 100
) (
  input wire logic clock_in,
  input wire logic bad_in,
  input wire fpe_pkg::fpe_pins_t pins_in,
  output logic [7:0] dq_out,
  output logic ready_busy_n_out
);
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  logic [7:0] want = 8'h00;
  logic [7:0] pa = 8'h00;
  int cnt = 0;
  logic we_q = 1'b1, ce_q = 1'b1, rd_q = 1'b0, tog = 1'b0, armed = 1'b0, erase = 1'b0;
  wire rd = !pins_in.ce_n && !pins_in.oe_n && !pins_in.dq_oe;
  // complement while busy; nothing suspended, so bit 2 stays still
  wire [7:0] stat = {~want[7], tog, 6'h00};
  // Released bus shows inverse, never a stale value
  assign dq_out = rd ? (cnt != 0 ? stat : mem[pins_in.addr[7:0]]) : ~last;
  assign ready_busy_n_out = (cnt == 0);
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  always @(posedge clock_in) begin
    we_q <= pins_in.we_n;
    ce_q <= pins_in.ce_n;
    rd_q <= rd;
    if (rd) last <= dq_out;
    if (rd && !rd_q && cnt != 0) tog <= ~tog;
    if (!pins_in.reset_n) begin
      cnt <= 0;
      armed <= 1'b0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      if (erase) for (int i = 0; i < 256; i++) mem[i] <= 8'hFF;
      else mem[pa] <= bad_in ? want ^ 8'h80 : want;
    end else if (!we_q && pins_in.we_n && !ce_q && !pins_in.addr_hv) begin
      if (armed) begin
        cnt <= PROG_CYC;
        want <= pins_in.dq;
        pa <= pins_in.addr[7:0];
        erase <= 1'b0;
        armed <= 1'b0;
      end else if (pins_in.dq == fpe_pkg::CMD_PROG) begin
        armed <= 1'b1;
      end else if (pins_in.dq == fpe_pkg::CMD_SECTOR_ERASE) begin
        cnt <= ERASE_CYC;
        want <= 8'hFF;
        erase <= 1'b1;
      end
    end
  end
endmodule

// >>> testbench/fpe_host_test.sv
// Self-checking bench for the flash sequencer host
`timescale 1ns/1ps
module fpe_host_test;
  logic clock_in = 0, rst_b_in = 0, cmd_valid_in = 0, abort_in = 0, bad = 0, hv_sel = 0;
  fpe_pkg::fpe_cmd_t cmd_in = '0;
  logic busy_out, done_out, error_out, tu_active_out, rb_n;
  logic [7:0] rdata_out, dq, d;
  logic [19:0] a;
  fpe_pkg::fpe_pins_t pins;
  logic [7:0] sh [256];
  int n_fail = 0, checks = 0, seed = 53, cyc = 0, sel_cnt = 0, we_cnt = 0, hv_cnt = 0, n_wr = 0;
  int wr0 = 0, rb_cnt = 0;
  localparam int SIM_WPP1 = 20;
  localparam int SIM_WPP2 = 40;
  always #5 clock_in = ~clock_in;
  fpe_host #(.WPP1_CYC(SIM_WPP1), .WPP2_CYC(SIM_WPP2), .PROG_TO_CYC(200), .ERASE_TO_CYC(500)) dut (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .abort_in(abort_in),
    .flash_dq_in(dq), .flash_ready_busy_n_in(rb_n), .busy_out(busy_out), .done_out(done_out), .error_out(error_out),
    .rdata_out(rdata_out), .tu_active_out(tu_active_out), .flash_pins_out(pins));
  fpe_flash_model model (.clock_in(clock_in), .bad_in(bad), .pins_in(pins), .dq_out(dq), .ready_busy_n_out(rb_n));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Shortest legal protect pulse for the chosen direction
  function automatic int wpp_min(input logic unprot);
    return unprot ? SIM_WPP2 : SIM_WPP1;
  endfunction
  // Bus writes one program command needs
  function automatic int writes_for(input fpe_pkg::fpe_op_t op);
    return (op == fpe_pkg::OP_PROGRAM_BYP) ? 2 : 4;
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic run(input fpe_pkg::fpe_op_t op, input logic [19:0] ad, input logic [7:0] dt, input int ab);
    int k;
    @(negedge clock_in);
    cmd_in = '{op: op, addr: ad, data: dt};
    cmd_valid_in = 1;
    wr0 = n_wr;
    @(negedge clock_in);
    cmd_valid_in = 0;
    check({7'h00, busy_out}, 8'h01);
    k = 0;
    while (done_out !== 1'b1 && k < 5000) begin
      abort_in = (k == ab);
      @(negedge clock_in);
      k++;
    end
    abort_in = 0;
    check({7'h00, done_out}, 8'h01);
    check({7'h00, busy_out}, 8'h00);
    $display("test op %0d done", op);
  endtask
  // ----------------------------------------
  // Pin monitor and timeout
  // ----------------------------------------
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    sel_cnt <= (!pins.ce_n && !pins.oe_n) ? sel_cnt + 1 : 0;
    we_cnt <= !pins.we_n ? we_cnt + 1 : 0;
    hv_cnt <= pins.reset_hv ? hv_cnt + 1 : 0;
    rb_cnt <= (rb_n && pins.reset_hv) ? rb_cnt + 1 : 0;
    if (!pins.we_n && we_cnt == 0) n_wr <= n_wr + 1;
    if (!pins.we_n && we_cnt == 0 && pins.addr_hv) begin
      check({7'h00, sel_cnt >= fpe_pkg::SETUP_CYC}, 8'h01);
      check({5'h00, pins.addr[6], pins.addr[1:0]}, {5'h00, hv_sel, 2'h2});
    end
    if (pins.we_n && we_cnt > 0 && pins.addr_hv) check({7'h00, we_cnt >= wpp_min(hv_sel)}, 8'h01);
    if (!pins.we_n && we_cnt == 0 && pins.reset_hv) check({7'h00, hv_cnt >= fpe_pkg::SETUP_CYC}, 8'h01);
    if (!pins.reset_hv && hv_cnt > 0 && pins.reset_n) check({7'h00, rb_cnt >= fpe_pkg::SETUP_CYC}, 8'h01);
    if (cyc == 40000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    for (int i = 0; i < 256; i++) sh[i] = 8'(i) ^ 8'h5A;
    repeat (10) @(negedge clock_in);
    rst_b_in = 1;
    repeat (5) begin
      a = 20'($random(seed));
      d = 8'($random(seed));
      run(fpe_pkg::OP_PROGRAM, a, d, -1);
      check(8'(n_wr - wr0), 8'(writes_for(fpe_pkg::OP_PROGRAM)));
      check({7'h00, error_out}, 8'h00);
      sh[a[7:0]] = d;
      run(fpe_pkg::OP_READ, a, 8'h00, -1);
      check(rdata_out, sh[a[7:0]]);
    end
    run(fpe_pkg::OP_BYP_ENTER, 20'h00000, 8'h00, -1);
    run(fpe_pkg::OP_PROGRAM_BYP, 20'h00011, 8'h00, -1);
    check(8'(n_wr - wr0), 8'(writes_for(fpe_pkg::OP_PROGRAM_BYP)));
    run(fpe_pkg::OP_BYP_EXIT, 20'h00000, 8'h00, -1);
    // Wrong byte stored must be reported
    bad = 1;
    run(fpe_pkg::OP_PROGRAM, 20'h00022, 8'h0F, -1);
    check({7'h00, error_out}, 8'h01);
    bad = 0;
    run(fpe_pkg::OP_PROGRAM, 20'h00033, 8'hC3, 90);
    check({7'h00, error_out}, 8'h01);
    check({7'h00, rb_n}, 8'h01);
    run(fpe_pkg::OP_READ, 20'h00033, 8'h00, -1);
    check(rdata_out, sh[8'h33]);
    run(fpe_pkg::OP_ERASE, 20'h10000, 8'h00, -1);
    check({7'h00, error_out}, 8'h00);
    run(fpe_pkg::OP_READ, 20'($random(seed)), 8'h00, -1);
    check(rdata_out, 8'hFF);
    run(fpe_pkg::OP_PROTECT, 20'h20000, 8'h00, -1);
    hv_sel = 1;
    run(fpe_pkg::OP_UNPROTECT, 20'h20000, 8'h00, -1);
    run(fpe_pkg::OP_TU_ENTER, 20'h00000, 8'h00, -1);
    check({7'h00, tu_active_out}, 8'h01);
    run(fpe_pkg::OP_PROGRAM, 20'h00044, 8'h12, -1);
    run(fpe_pkg::OP_TU_EXIT, 20'h00000, 8'h00, -1);
    check({7'h00, tu_active_out}, 8'h00);
    end_of_test();
  end
endmodule
